// *** bbfe_pkg.sv ***
/*
 * Package of the branch, bit and flag execution block: opcode codes, flag
 * positions, register offsets and reset values.
 * Assumes a fetch/decode stage outside that hands over one decoded opcode at
 * a time and an I/O register space that answers a read one cycle later.
 */
// Behaviour
// - branch_if_lower: with carry 1, PC gets PC plus offset plus one.
// - branch_if_minus: branch to PC plus offset plus one when negative is 1.
// - branch_if_plus: branch to PC plus offset plus one when negative is 0.
// - branch_if_ge_signed: branch when negative xor overflow is 0.
// - branch_if_lt_signed: branch when negative xor overflow is 1; flags kept.
// - branch_if_halfcarry_set: branch only when half-carry is 1.
// - branch_if_halfcarry_clear: branch only when half-carry is 0.
// - branch_if_transfer_set: branch only when transfer flag is 1.
// - branch_if_transfer_clear: branch only when transfer flag is 0.
// - branch_if_overflow_clear: branch only when overflow is 0.
// - branch_if_irq_enabled: branch only when global interrupt enable is 1.
// - branch_if_irq_disabled: branch only when global interrupt enable is 0.
// - io_bit_set forces one I/O register bit to 1, two cycles, flags kept.
// - io_bit_clear forces one I/O register bit to 0, two cycles, flags kept.
// - logical_left_shift: bits up, 0 into bit 0, updates Z C N V.
// - logical_right_shift: bits down, 0 into bit 7, updates Z C N V.
// - rotate_left_carry: old carry into bit 0, old bit 7 into carry.
// - rotate_right_carry: old carry into bit 7, old bit 0 into carry.
// - arith_right_shift: bits down, bit 7 kept, updates Z C N V.
// - bit_to_transfer_flag copies a source bit into transfer flag only.
// - transfer_flag_to_bit copies transfer flag into a destination bit.
// - one-cycle set/clear for each flag, plus set/clear by index.
`default_nettype none
package bbfe_pkg;

	// status flag positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;

	// register port offsets
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_PC = 2'h1;
	localparam logic [1:0] REG_INFO = 2'h2;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;

	// cycles an instruction occupies the block
	localparam int BRANCH_TAKEN_CYCLES = 2;
	localparam int IO_BIT_CYCLES = 2;

	typedef enum logic [5:0] {
		OP_BRANCH_IF_LOWER = 6'h00,
		OP_BRANCH_IF_MINUS = 6'h01,
		OP_BRANCH_IF_PLUS = 6'h02,
		OP_BRANCH_IF_GE_SIGNED = 6'h03,
		OP_BRANCH_IF_LT_SIGNED = 6'h04,
		OP_BRANCH_IF_HALFCARRY_SET = 6'h05,
		OP_BRANCH_IF_HALFCARRY_CLEAR = 6'h06,
		OP_BRANCH_IF_TRANSFER_SET = 6'h07,
		OP_BRANCH_IF_TRANSFER_CLEAR = 6'h08,
		OP_BRANCH_IF_OVERFLOW_CLEAR = 6'h09,
		OP_BRANCH_IF_IRQ_ENABLED = 6'h0A,
		OP_BRANCH_IF_IRQ_DISABLED = 6'h0B,
		OP_IO_BIT_SET = 6'h10,
		OP_IO_BIT_CLEAR = 6'h11,
		OP_LOGICAL_LEFT_SHIFT = 6'h12,
		OP_LOGICAL_RIGHT_SHIFT = 6'h13,
		OP_ROTATE_LEFT_CARRY = 6'h14,
		OP_ROTATE_RIGHT_CARRY = 6'h15,
		OP_ARITH_RIGHT_SHIFT = 6'h16,
		OP_BIT_TO_TRANSFER_FLAG = 6'h17,
		OP_TRANSFER_FLAG_TO_BIT = 6'h18,
		OP_STATUS_BIT_SET = 6'h19,
		OP_STATUS_BIT_CLEAR = 6'h1A,
		OP_SET_CARRY = 6'h20,
		OP_SET_ZERO = 6'h21,
		OP_SET_NEGATIVE = 6'h22,
		OP_SET_OVERFLOW = 6'h23,
		OP_SET_SIGN = 6'h24,
		OP_SET_HALFCARRY = 6'h25,
		OP_SET_TRANSFER = 6'h26,
		OP_GLOBAL_IRQ_ENABLE = 6'h27,
		OP_CLEAR_CARRY = 6'h28,
		OP_CLEAR_ZERO = 6'h29,
		OP_CLEAR_NEGATIVE = 6'h2A,
		OP_CLEAR_OVERFLOW = 6'h2B,
		OP_CLEAR_SIGN = 6'h2C,
		OP_CLEAR_HALFCARRY = 6'h2D,
		OP_CLEAR_TRANSFER = 6'h2E,
		OP_GLOBAL_IRQ_DISABLE = 6'h2F
	} bbfe_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BRANCH = 2'b01,
		ST_IO = 2'b11
	} bbfe_state_e;

endpackage : bbfe_pkg

`default_nettype wire

// *** bbfe_core.sv ***
/*
 * Execution unit for conditional relative branches, I/O bit set/clear,
 * shifts and rotates, transfer-flag bit moves and flag set/clear. It owns
 * the program counter and the status flags.
 * Assumes: one opcode offered with OP_VALID, taken while OP_READY is high;
 * the I/O space returns IO_RDATA in the cycle after IO_RD; all inputs are
 * synchronous to CORE_CLK.
 */
`timescale 1ns/100ps
`default_nettype none

module bbfe_core
	import bbfe_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int OFF_W = 7,
	parameter int IO_AW = 6
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic OP_VALID,
	output logic OP_READY,
	input wire logic [5:0] OP_CODE,
	input wire logic [7:0] OP_DATA,
	input wire logic [2:0] OP_BIT,
	input wire logic [OFF_W-1:0] OP_OFFSET,
	input wire logic [IO_AW-1:0] OP_IO_ADDR,
	output logic RES_VALID,
	output logic [7:0] RES_DATA,
	output logic [PC_W-1:0] PROG_CNT,
	output logic [7:0] STATUS_FLAGS,
	output logic IO_RD,
	output logic [IO_AW-1:0] IO_ADDR,
	input wire logic [7:0] IO_RDATA,
	output logic IO_WR,
	output logic [7:0] IO_WDATA,
	input wire logic [1:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA
);

	if (PC_W < 2 || PC_W > 16 || OFF_W < 2 || OFF_W >= PC_W || IO_AW < 1 || IO_AW > 16) begin : g_chk
		$error("bbfe_core: unsupported width parameters");
	end

	bbfe_state_e state;
	bbfe_state_e next_state;
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] next_pc;
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic res_valid;
	logic next_res_valid;
	logic [7:0] res_data;
	logic [7:0] next_res_data;
	logic [IO_AW-1:0] io_addr;
	logic [IO_AW-1:0] next_io_addr;
	logic [2:0] io_bit;
	logic [2:0] next_io_bit;
	logic io_set;
	logic next_io_set;
	logic io_wr;
	logic next_io_wr;
	logic [7:0] io_wdata;
	logic [7:0] next_io_wdata;
	logic last_taken;
	logic next_last_taken;
	logic [15:0] rdata;
	logic [15:0] next_rdata;

	logic take;
	logic [PC_W-1:0] offset_ext;
	logic [PC_W-1:0] target;

	// condition of each branch opcode; 0 for anything that is not a branch
	function automatic logic branch_cond(input logic [5:0] op, input logic [7:0] f);
		logic c;
		c = 1'b0;
		unique case (op)
			OP_BRANCH_IF_LOWER: c = f[FLAG_C];
			OP_BRANCH_IF_MINUS: c = f[FLAG_N];
			OP_BRANCH_IF_PLUS: c = ~f[FLAG_N];
			OP_BRANCH_IF_GE_SIGNED: c = ~(f[FLAG_N] ^ f[FLAG_V]);
			OP_BRANCH_IF_LT_SIGNED: c = f[FLAG_N] ^ f[FLAG_V];
			OP_BRANCH_IF_HALFCARRY_SET: c = f[FLAG_H];
			OP_BRANCH_IF_HALFCARRY_CLEAR: c = ~f[FLAG_H];
			OP_BRANCH_IF_TRANSFER_SET: c = f[FLAG_T];
			OP_BRANCH_IF_TRANSFER_CLEAR: c = ~f[FLAG_T];
			OP_BRANCH_IF_OVERFLOW_CLEAR: c = ~f[FLAG_V];
			OP_BRANCH_IF_IRQ_ENABLED: c = f[FLAG_I];
			OP_BRANCH_IF_IRQ_DISABLED: c = ~f[FLAG_I];
			default: c = 1'b0;
		endcase
		return c;
	endfunction : branch_cond

	// shift/rotate result with carry-out in bit 8
	function automatic logic [8:0] shift_op(input logic [5:0] op, input logic [7:0] d,
			input logic cin);
		logic [8:0] r;
		r = {1'b0, d};
		unique case (op)
			OP_LOGICAL_LEFT_SHIFT: r = {d[7], d[6:0], 1'b0};
			OP_LOGICAL_RIGHT_SHIFT: r = {d[0], 1'b0, d[7:1]};
			OP_ROTATE_LEFT_CARRY: r = {d[7], d[6:0], cin};
			OP_ROTATE_RIGHT_CARRY: r = {d[0], cin, d[7:1]};
			OP_ARITH_RIGHT_SHIFT: r = {d[0], d[7], d[7:1]};
			default: r = {cin, d};
		endcase
		return r;
	endfunction : shift_op

	// sign extension keeps backward targets reachable
	assign offset_ext = {{(PC_W-OFF_W){OP_OFFSET[OFF_W-1]}}, OP_OFFSET};
	assign target = pc + offset_ext + PC_W'(1);
	assign take = branch_cond(OP_CODE, flags);

	assign OP_READY = (state == ST_IDLE);
	// read strobe leaves in the accept cycle so the data is back for cycle two
	assign IO_RD = OP_VALID && (state == ST_IDLE)
		&& (OP_CODE == OP_IO_BIT_SET || OP_CODE == OP_IO_BIT_CLEAR);
	assign IO_ADDR = (state == ST_IO) ? io_addr : OP_IO_ADDR;

	assign RES_VALID = res_valid;
	assign RES_DATA = res_data;
	assign PROG_CNT = pc;
	assign STATUS_FLAGS = flags;
	assign IO_WR = io_wr;
	assign IO_WDATA = io_wdata;
	assign REG_RDATA = rdata;

	always_comb begin
		logic [8:0] sh;
		logic [7:0] mod;
		sh = shift_op(OP_CODE, OP_DATA, flags[FLAG_C]);
		mod = IO_RDATA;
		next_state = state;
		next_pc = pc;
		next_flags = flags;
		next_res_valid = 1'b0;
		next_res_data = res_data;
		next_io_addr = io_addr;
		next_io_bit = io_bit;
		next_io_set = io_set;
		next_io_wr = 1'b0;
		next_io_wdata = io_wdata;
		next_last_taken = last_taken;
		next_rdata = rdata;

		// software writes first, so a same-cycle instruction update wins
		if (REG_WR) begin
			unique case (REG_ADDR)
				REG_STATUS: next_flags = REG_WDATA[7:0];
				REG_PC: next_pc = REG_WDATA[PC_W-1:0];
				default: ;
			endcase
		end

		unique case (state)
			ST_IDLE: begin
				if (OP_VALID) begin
					next_pc = pc + PC_W'(1);
					unique case (OP_CODE)
						OP_BRANCH_IF_LOWER, OP_BRANCH_IF_MINUS, OP_BRANCH_IF_PLUS,
						OP_BRANCH_IF_GE_SIGNED, OP_BRANCH_IF_LT_SIGNED,
						OP_BRANCH_IF_HALFCARRY_SET, OP_BRANCH_IF_HALFCARRY_CLEAR,
						OP_BRANCH_IF_TRANSFER_SET, OP_BRANCH_IF_TRANSFER_CLEAR,
						OP_BRANCH_IF_OVERFLOW_CLEAR, OP_BRANCH_IF_IRQ_ENABLED,
						OP_BRANCH_IF_IRQ_DISABLED: begin
							next_last_taken = take;
							if (take) begin
								next_pc = target;
								next_state = ST_BRANCH;
							end
						end
						OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
							next_io_addr = OP_IO_ADDR;
							next_io_bit = OP_BIT;
							next_io_set = (OP_CODE == OP_IO_BIT_SET);
							next_state = ST_IO;
						end
						OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
						OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT: begin
							next_res_valid = 1'b1;
							next_res_data = sh[7:0];
							next_flags[FLAG_C] = sh[8];
							next_flags[FLAG_Z] = (sh[7:0] == 8'h00);
							next_flags[FLAG_N] = sh[7];
							next_flags[FLAG_V] = sh[7] ^ sh[8];
						end
						OP_BIT_TO_TRANSFER_FLAG: begin
							next_flags[FLAG_T] = OP_DATA[OP_BIT];
						end
						OP_TRANSFER_FLAG_TO_BIT: begin
							next_res_valid = 1'b1;
							next_res_data = OP_DATA;
							next_res_data[OP_BIT] = flags[FLAG_T];
						end
						OP_STATUS_BIT_SET: next_flags[OP_BIT] = 1'b1;
						OP_STATUS_BIT_CLEAR: next_flags[OP_BIT] = 1'b0;
						OP_SET_CARRY, OP_SET_ZERO, OP_SET_NEGATIVE, OP_SET_OVERFLOW,
						OP_SET_SIGN, OP_SET_HALFCARRY, OP_SET_TRANSFER,
						OP_GLOBAL_IRQ_ENABLE, OP_CLEAR_CARRY, OP_CLEAR_ZERO,
						OP_CLEAR_NEGATIVE, OP_CLEAR_OVERFLOW, OP_CLEAR_SIGN,
						OP_CLEAR_HALFCARRY, OP_CLEAR_TRANSFER, OP_GLOBAL_IRQ_DISABLE: begin
							// low three code bits name the flag, bit 3 selects clear
							next_flags[OP_CODE[2:0]] = ~OP_CODE[3];
						end
						default: ; // unknown codes only advance the counter
					endcase
				end
			end
			ST_BRANCH: begin
				// second cycle of a taken branch: the refill slot
				next_state = ST_IDLE;
			end
			ST_IO: begin
				// only the selected bit changes; the rest of the byte is written back as read
				mod[io_bit] = io_set;
				next_io_wdata = mod;
				next_io_wr = 1'b1;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase

		if (REG_RD) begin
			unique case (REG_ADDR)
				REG_STATUS: next_rdata = {8'h00, flags};
				REG_PC: next_rdata = 16'(pc);
				REG_INFO: next_rdata = {13'h0000, last_taken, state};
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			pc <= PC_W'(PC_RST);
			flags <= STATUS_RST;
			res_valid <= 1'b0;
			res_data <= 8'h00;
			io_addr <= '0;
			io_bit <= 3'h0;
			io_set <= 1'b0;
			io_wr <= 1'b0;
			io_wdata <= 8'h00;
			last_taken <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			state <= next_state;
			pc <= next_pc;
			flags <= next_flags;
			res_valid <= next_res_valid;
			res_data <= next_res_data;
			io_addr <= next_io_addr;
			io_bit <= next_io_bit;
			io_set <= next_io_set;
			io_wr <= next_io_wr;
			io_wdata <= next_io_wdata;
			last_taken <= next_last_taken;
			rdata <= next_rdata;
		end
	end

endmodule : bbfe_core

`default_nettype wire

// *** bbfe_io_model.sv ***
/* I/O register space model: 64 bytes, a read answered in the cycle after IO_RD.
   Assumes the unit's address is valid only beside IO_RD. */
`timescale 1ns/100ps
`default_nettype none
module bbfe_io_model (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic IO_RD,
	input wire logic [5:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA
);
	logic [7:0] mem [64];
	logic [7:0] rd;
	logic [5:0] a;
	logic vld;
	// outside the answer cycle the bus shows the inverse, so stale data cannot pass
	assign IO_RDATA = vld ? rd : ~rd;
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 64; i++) begin
				mem[i] <= i[7:0] ^ 8'hA5;
			end
			vld <= 1'b0;
			rd <= 8'h00;
			a <= 6'h00;
		end else begin
			vld <= IO_RD;
			if (IO_RD) begin
				a <= IO_ADDR;
				rd <= mem[IO_ADDR];
			end
			// write address comes from the read cycle, the unit drops it later
			if (IO_WR) begin
				mem[a] <= IO_WDATA;
			end
		end
	end
endmodule : bbfe_io_model
`default_nettype wire

// *** bbfe_core_assertions.sv ***
/* Checker for the branch, bit and flag unit, bound to its top module.
   Assumes no register write is made in the cycle an opcode is taken. */
`timescale 1ns/100ps
`default_nettype none
module bbfe_core_assertions
	import bbfe_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int OFF_W = 7
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic OP_VALID,
	input wire logic OP_READY,
	input wire logic [5:0] OP_CODE,
	input wire logic [7:0] OP_DATA,
	input wire logic [2:0] OP_BIT,
	input wire logic [OFF_W-1:0] OP_OFFSET,
	input wire logic IO_RD,
	input wire logic IO_WR,
	input wire logic [7:0] IO_WDATA,
	input wire logic [7:0] IO_RDATA,
	input wire logic RES_VALID,
	input wire logic [7:0] RES_DATA,
	input wire logic [PC_W-1:0] PROG_CNT,
	input wire logic [7:0] STATUS_FLAGS,
	input wire logic REG_WR
);
	logic acc, br, cond;
	logic [11:0] cv;
	logic [7:0] f;
	logic [PC_W-1:0] tgt, nxt;
	assign f = STATUS_FLAGS;
	assign acc = OP_VALID && OP_READY && !REG_WR;
	assign br = acc && OP_CODE < 6'h0C;
	// one condition bit per branch code, code 0 in bit 0
	assign cv = {~f[7], f[7], ~f[3], ~f[6], f[6], ~f[5], f[5],
		f[2] ^ f[3], f[2] ~^ f[3], ~f[2], f[2], f[0]};
	assign cond = cv[OP_CODE[3:0]];
	assign tgt = PROG_CNT + {{(PC_W-OFF_W){OP_OFFSET[OFF_W-1]}}, OP_OFFSET} + 1'b1;
	assign nxt = PROG_CNT + 1'b1;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	chk_branch_taken: assert property (
		br && cond |=> PROG_CNT == $past(tgt) && !OP_READY)
		else $error("taken branch target or busy slot wrong");
	chk_branch_skip: assert property (br && !cond |=> PROG_CNT == $past(nxt) && OP_READY)
		else $error("untaken branch did not step by one");
	chk_branch_flags: assert property (br |=> $stable(STATUS_FLAGS))
		else $error("branch changed flags");
	chk_io_sequence: assert property (
		acc && IO_RD |=> (!OP_READY && !IO_WR && $stable(f)) ##1 (IO_WR && $stable(f)))
		else $error("io bit operation timing wrong");
	chk_io_set_bit: assert property (
		IO_WR |-> IO_WDATA[$past(OP_BIT, 2)] == ($past(OP_CODE, 2) == OP_IO_BIT_SET))
		else $error("io target bit wrong");
	chk_io_other_bits: assert property (
		IO_WR |-> ((IO_WDATA ^ $past(IO_RDATA)) & ~(8'h01 << $past(OP_BIT, 2))) == 8'h00)
		else $error("io other bits changed");
	chk_shift_left: assert property (
		acc && OP_CODE == OP_LOGICAL_LEFT_SHIFT |=> RES_VALID
		&& RES_DATA == {$past(OP_DATA[6:0]), 1'b0} && f[0] == $past(OP_DATA[7]))
		else $error("left shift result wrong");
	chk_rotate_right: assert property (
		acc && OP_CODE == OP_ROTATE_RIGHT_CARRY
		|=> RES_DATA == {$past(f[0]), $past(OP_DATA[7:1])} && f[0] == $past(OP_DATA[0]))
		else $error("right rotate result wrong");
	chk_bit_to_t: assert property (
		acc && OP_CODE == OP_BIT_TO_TRANSFER_FLAG
		|=> f == ($past(f) & 8'hBF | {$past(OP_DATA[OP_BIT]), 6'h00}))
		else $error("transfer flag store wrong");
	chk_flag_op: assert property (
		acc && OP_CODE[5:4] == 2'h2 |=> f[$past(OP_CODE[2:0])] == !$past(OP_CODE[3]))
		else $error("dedicated flag op wrong");
	cover property (br && cond);
	cover property (acc && IO_RD);
	cover property (acc && OP_CODE[5:4] == 2'h2);
endmodule : bbfe_core_assertions
`default_nettype wire

// *** branch_bit_flag_exec_tb.sv ***
/* Bench for the branch, bit and flag unit with the I/O space model.
   Assumes the checker file is compiled before this one; it is bound here. */
`timescale 1ns/100ps
`default_nettype none
module branch_bit_flag_exec_tb
	import bbfe_pkg::*;
;
	typedef struct packed {logic [5:0] op; logic [7:0] d; logic [2:0] b;
		logic [7:0] fi, fo, r;} bbfe_row_s;
	logic CORE_CLK = 0, RST_N = 0, OP_VALID = 0, REG_WR = 0, REG_RD = 0;
	logic OP_READY, RES_VALID, IO_RD, IO_WR;
	logic [5:0] OP_CODE = 0, OP_IO_ADDR = 0, IO_ADDR, c6;
	logic [7:0] OP_DATA = 0, RES_DATA, STATUS_FLAGS, IO_RDATA, IO_WDATA, f8;
	logic [2:0] OP_BIT = 0;
	logic [6:0] OP_OFFSET = 0, k;
	logic [15:0] PROG_CNT, REG_WDATA = 0, REG_RDATA, e;
	logic [1:0] REG_ADDR = 0;
	int err_count = 0, checks_done = 0;
	// taken masks per branch code for flags 00, FF and N alone
	logic [11:0] mask [3] = '{12'hB4C, 12'h4AB, 12'hB52};
	logic [7:0] fl [3] = '{8'h00, 8'hFF, 8'h04};
	bbfe_row_s rows [9] = '{'{OP_LOGICAL_LEFT_SHIFT, 8'h81, 3'h0, 8'h00, 8'h09, 8'h02},
		'{OP_LOGICAL_RIGHT_SHIFT, 8'h01, 3'h0, 8'h00, 8'h0B, 8'h00},
		'{OP_ROTATE_LEFT_CARRY, 8'h80, 3'h0, 8'h01, 8'h09, 8'h01},
		'{OP_ROTATE_RIGHT_CARRY, 8'h01, 3'h0, 8'h01, 8'h05, 8'h80},
		'{OP_ARITH_RIGHT_SHIFT, 8'h82, 3'h0, 8'h00, 8'h0C, 8'hC1},
		'{OP_BIT_TO_TRANSFER_FLAG, 8'h10, 3'h4, 8'h00, 8'h40, 8'hC1},
		'{OP_TRANSFER_FLAG_TO_BIT, 8'h00, 3'h3, 8'h40, 8'h40, 8'h08},
		'{OP_STATUS_BIT_SET, 8'h00, 3'h5, 8'h00, 8'h20, 8'h08},
		'{OP_STATUS_BIT_CLEAR, 8'h00, 3'h5, 8'hFF, 8'hDF, 8'h08}};
	always #20 CORE_CLK = ~CORE_CLK;
	bbfe_core bbfe_core_inst (.CORE_CLK, .RST_N, .OP_VALID, .OP_READY, .OP_CODE, .OP_DATA,
		.OP_BIT, .OP_OFFSET, .OP_IO_ADDR, .RES_VALID, .RES_DATA, .PROG_CNT, .STATUS_FLAGS,
		.IO_RD, .IO_ADDR, .IO_RDATA, .IO_WR, .IO_WDATA, .REG_ADDR, .REG_WDATA, .REG_WR,
		.REG_RD, .REG_RDATA);
	bbfe_io_model bbfe_io_model_inst (.CORE_CLK, .RST_N, .IO_RD, .IO_ADDR, .IO_WR, .IO_WDATA,
		.IO_RDATA);
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		checks_done++;
		if (g !== x) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic reg_acc(input logic wr, input logic [1:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= wr;
		REG_RD <= !wr;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1;
		if (!wr) chk(REG_RDATA, d);
	endtask : reg_acc
	task automatic op(input logic [5:0] c, input logic [7:0] d, input logic [2:0] b,
		input logic [6:0] o, input logic [5:0] a);
		int n;
		n = 0;
		@(posedge CORE_CLK);
		OP_VALID <= 1'b1;
		OP_CODE <= c;
		OP_DATA <= d;
		OP_BIT <= b;
		OP_OFFSET <= o;
		OP_IO_ADDR <= a;
		do @(posedge CORE_CLK); while (!OP_READY && ++n < 4);
		OP_VALID <= 1'b0;
		#1;
		// an offer never taken within the limit is a mismatch
		if (n == 4) chk(16'(n), 16'h0000);
	endtask : op
	task automatic final_report();
		$display("mismatches %0d of %0d checks", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	initial begin
		#100000;
		err_count++;
		final_report();
	end
	initial begin
		repeat (4) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		foreach (rows[i]) begin
			reg_acc(1'b1, REG_STATUS, {8'h00, rows[i].fi});
			reg_acc(1'b1, REG_PC, 16'h0100);
			op(rows[i].op, rows[i].d, rows[i].b, 7'h00, 6'h00);
			chk(STATUS_FLAGS, rows[i].fo);
			chk(RES_DATA, rows[i].r);
			chk(RES_VALID, rows[i].op < OP_STATUS_BIT_SET
				&& rows[i].op != OP_BIT_TO_TRANSFER_FLAG);
			chk(PROG_CNT, 16'h0101);
		end
		for (int r = 0; r < 3; r++) begin
			for (int c = 0; c < 12; c++) begin
				reg_acc(1'b1, REG_STATUS, {8'h00, fl[r]});
				reg_acc(1'b1, REG_PC, 16'h0100);
				k = c[0] ? 7'h40 : 7'h3F;
				op(c[5:0], 8'h00, 3'h0, k, 6'h00);
				e = mask[r][c] ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
				chk(PROG_CNT, e);
				chk(OP_READY, !mask[r][c]);
				chk(STATUS_FLAGS, fl[r]);
			end
		end
		for (int i = 0; i < 16; i++) begin
			c6 = 6'h20 + i[5:0];
			f8 = c6[3] ? 8'hFF : 8'h00;
			reg_acc(1'b1, REG_STATUS, {8'h00, f8});
			op(c6, 8'h00, 3'h0, 7'h00, 6'h00);
			chk(STATUS_FLAGS, f8 ^ (8'h01 << c6[2:0]));
		end
		reg_acc(1'b1, REG_STATUS, 16'h0000);
		// second io op is offered while the first one writes back
		op(OP_IO_BIT_SET, 8'h00, 3'h3, 7'h00, 6'h05);
		op(OP_IO_BIT_CLEAR, 8'h00, 3'h3, 7'h00, 6'h09);
		repeat (2) @(posedge CORE_CLK);
		#1;
		chk(bbfe_io_model_inst.mem[5], 8'hA8);
		chk(bbfe_io_model_inst.mem[9], 8'hA4);
		chk(STATUS_FLAGS, 8'h00);
		reg_acc(1'b1, REG_PC, 16'h1234);
		reg_acc(1'b0, REG_PC, 16'h1234);
		reg_acc(1'b0, 2'h3, 16'h0000);
		reg_acc(1'b1, REG_INFO, 16'hFFFF);
		reg_acc(1'b0, REG_INFO, 16'h0004);
		reg_acc(1'b1, REG_STATUS, 16'h00FF);
		// reset in mid-run must clear state well before the next edge
		@(posedge CORE_CLK);
		RST_N <= 1'b0;
		#1;
		chk(STATUS_FLAGS, STATUS_RST);
		chk(PROG_CNT, PC_RST);
		chk(OP_READY, 1'b1);
		@(posedge CORE_CLK);
		RST_N <= 1'b1;
		// the unit must take work again right after release
		op(OP_SET_CARRY, 8'h00, 3'h0, 7'h00, 6'h00);
		chk(STATUS_FLAGS, 8'h01);
		chk(PROG_CNT, PC_RST + 16'h0001);
		final_report();
	end
endmodule : branch_bit_flag_exec_tb
bind bbfe_core bbfe_core_assertions #(.PC_W(PC_W), .OFF_W(OFF_W)) bbfe_core_assertions_inst (
	.CORE_CLK, .RST_N, .OP_VALID, .OP_READY, .OP_CODE, .OP_DATA, .OP_BIT, .OP_OFFSET, .IO_RD,
	.IO_WR, .IO_WDATA, .IO_RDATA, .RES_VALID, .RES_DATA, .PROG_CNT, .STATUS_FLAGS, .REG_WR);
`default_nettype wire
